/* File: core/fidp_consts.svh */
`ifndef FIDP_CONSTS_SVH
`define FIDP_CONSTS_SVH

// ***********************************
// Register map (word offsets on the plain port)
// ***********************************
`define FIDP_ADDR_W 4
`define FIDP_A_CONFIG 4'h0
`define FIDP_A_PORT_VAL 4'h1
`define FIDP_A_RELAY 4'h2
`define FIDP_A_QUES_EVENT 4'h3
`define FIDP_A_QUES_ENABLE 4'h4
`define FIDP_A_OPER_EVENT 4'h5
`define FIDP_A_OPER_ENABLE 4'h6
`define FIDP_A_STD_EVENT 4'h7
`define FIDP_A_STD_ENABLE 4'h8
`define FIDP_A_PROT 4'h9
`define FIDP_A_STATUS 4'hA
`define FIDP_A_SRQ_ENABLE 4'hB

// ***********************************
// Field positions and values
// ***********************************
`define FIDP_MODE_FAULT_INH 2'h0
`define FIDP_MODE_DIGIO 2'h1
`define FIDP_MODE_RELAY 2'h2
`define FIDP_RI_BIT 9
`define FIDP_CFG_MODE_LO 0
`define FIDP_CFG_DIR2_BIT 2
`define FIDP_PROT_CLEAR_BIT 0
`define FIDP_RESET_CONFIG 8'h00
`define FIDP_RELAY_BITS 8
`define FIDP_RELAY_SYNC_BITS 2
`define FIDP_RELAY_DIV 16'h03E7
`define FIDP_STAT_ERR_CLR_BIT 3
`define FIDP_SRQ_EN_BIT 0
`define FIDP_PORT_BITS 3
`define FIDP_RELAY_FIRST_DATA 4'h1
`define FIDP_RELAY_LAST_DATA 4'h8
`define FIDP_RELAY_STOP_CNT 4'h9

`endif

/* File: core/fidp_pkg.sv */
package fidp_pkg;
  typedef enum logic [1:0] {
    FIDP_MODE_FI,
    FIDP_MODE_DIO,
    FIDP_MODE_RLY,
    FIDP_MODE_RSV
  } fidp_mode_t;

  typedef enum logic {
    FIDP_TX_IDLE,
    FIDP_TX_SHIFT
  } fidp_tx_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } fidp_bus_req_t;

  typedef struct packed {
    logic oper_summary;
    logic ques_summary;
    logic std_summary;
  } fidp_summary_t;

  typedef struct packed {
    logic [1:0] mode;
    logic dir2_out;
    logic [2:0] port_val;
    logic [7:0] relay_req;
    logic [7:0] relay_rb;
    logic [15:0] ques_ev;
    logic [15:0] ques_en;
    logic [15:0] oper_ev;
    logic [15:0] oper_en;
    logic [7:0] std_ev;
    logic [7:0] std_en;
    logic srq_en;
    logic ri_tripped;
    logic relay_err;
    logic [2:0] inh_sync;
    logic inh_level;
    logic [2:0] rtn_sync;
    logic rtn_level;
    logic [15:0] div_cnt;
    fidp_tx_state_t tx_state;
    logic [3:0] bit_cnt;
    logic [9:0] tx_shift;
    logic [7:0] rx_shift;
    logic [15:0] rdata;
  } fidp_state_t;
endpackage : fidp_pkg

/* File: core/fidp_port.sv */
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "fidp_consts.svh"

module fidp_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Status sources from the instrument
  input wire logic [15:0] ques_cond_in,
  input wire logic [15:0] oper_cond_in,
  input wire logic [7:0] std_event_in,
  input wire logic analog_prog_active,
  // Protection side
  output logic output_enable,
  output logic prot_indicator,
  output logic service_request,
  // Pin 1
  input wire logic line1_in,
  output logic line1_out,
  output logic line1_oe,
  // Pin 2
  input wire logic line2_in,
  output logic line2_out,
  output logic line2_oe,
  // Pin 3
  input wire logic line3_in,
  output logic line3_out,
  output logic line3_oe
);

  // ***********************************
  // State
  // ***********************************
  fidp_pkg::fidp_state_t s_reg;
  fidp_pkg::fidp_state_t s_next;
  fidp_pkg::fidp_bus_req_t req;
  fidp_pkg::fidp_summary_t sum;
  logic fault_active;
  logic inhibit_asserted;
  logic [15:0] ri_mask;
  logic port_bit2;
  logic tx_busy;
  logic fault_mode;
  logic digio_mode;
  logic relay_mode;

  // ***********************************
  // Helpers
  // ***********************************
  function automatic logic summary(input logic [15:0] ev, input logic [15:0] en);
    summary = |(ev & en);
  endfunction : summary

  function automatic logic [2:0] sync_shift(input logic [2:0] stages, input logic pin);
    sync_shift = {stages[1:0], pin};
  endfunction : sync_shift

  function automatic logic sync_level(input logic [2:0] stages, input logic held);
    if (stages[2] == stages[1]) begin
      sync_level = stages[2];
    end else begin
      sync_level = held;
    end
  endfunction : sync_level

  function automatic logic mode_is(input logic [1:0] cur, input logic [1:0] want);
    mode_is = (cur == want);
  endfunction : mode_is

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign ri_mask = 16'h0001 << `FIDP_RI_BIT;
  assign inhibit_asserted = !s_reg.inh_level;
  assign tx_busy = (s_reg.tx_state == fidp_pkg::FIDP_TX_SHIFT);
  assign fault_mode = mode_is(s_reg.mode, `FIDP_MODE_FAULT_INH);
  assign digio_mode = mode_is(s_reg.mode, `FIDP_MODE_DIGIO);
  assign relay_mode = mode_is(s_reg.mode, `FIDP_MODE_RELAY);
  // Line three reads back its sensed level only while it is an input
  assign port_bit2 = (digio_mode && !s_reg.dir2_out) ? s_reg.inh_level
    : s_reg.port_val[2];

  // ***********************************
  // Status summaries
  // ***********************************

  assign sum.oper_summary = summary(s_reg.oper_ev, s_reg.oper_en);
  assign sum.ques_summary = summary(s_reg.ques_ev, s_reg.ques_en);
  assign sum.std_summary = summary({8'h00, s_reg.std_ev}, {8'h00, s_reg.std_en});
  assign fault_active = sum.oper_summary | sum.ques_summary | sum.std_summary;

  // ***********************************
  // Next state
  // ***********************************
  always_comb begin
    s_next = s_reg;

    // ***********************************
    // Pin synchronisers
    // ***********************************
    // Three stages; a change counts once stages two and three agree
    s_next.inh_sync = sync_shift(s_reg.inh_sync, line3_in);
    s_next.inh_level = sync_level(s_reg.inh_sync, s_reg.inh_level);
    s_next.rtn_sync = sync_shift(s_reg.rtn_sync, line3_in);
    s_next.rtn_level = sync_level(s_reg.rtn_sync, s_reg.rtn_level);

    // ***********************************
    // Register reads
    // ***********************************
    // Read-to-clear; later event sets still win over these clears
    s_next.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        `FIDP_A_CONFIG: begin
          s_next.rdata = {13'h0000, s_reg.dir2_out, s_reg.mode};
        end
        `FIDP_A_PORT_VAL: begin
          s_next.rdata = {13'h0000, port_bit2, s_reg.port_val[1:0]};
        end
        `FIDP_A_RELAY: begin
          s_next.rdata = {s_reg.relay_rb, s_reg.relay_req};
        end
        `FIDP_A_QUES_EVENT: begin
          s_next.rdata = s_reg.ques_ev;
          s_next.ques_ev = 16'h0000;
        end
        `FIDP_A_QUES_ENABLE: begin
          s_next.rdata = s_reg.ques_en;
        end
        `FIDP_A_OPER_EVENT: begin
          s_next.rdata = s_reg.oper_ev;
          s_next.oper_ev = 16'h0000;
        end
        `FIDP_A_OPER_ENABLE: begin
          s_next.rdata = s_reg.oper_en;
        end
        `FIDP_A_STD_EVENT: begin
          s_next.rdata = {8'h00, s_reg.std_ev};
          s_next.std_ev = 8'h00;
        end
        `FIDP_A_STD_ENABLE: begin
          s_next.rdata = {8'h00, s_reg.std_en};
        end
        `FIDP_A_PROT: begin
          s_next.rdata = {15'h0000, s_reg.ri_tripped};
        end
        `FIDP_A_STATUS: begin
          s_next.rdata = {9'h000,
            tx_busy,
            s_reg.relay_err,
            inhibit_asserted,
            sum.std_summary,
            sum.ques_summary,
            sum.oper_summary,
            fault_active};
        end
        `FIDP_A_SRQ_ENABLE: begin
          s_next.rdata = {15'h0000, s_reg.srq_en};
        end
        default: begin
          s_next.rdata = 16'h0000;
        end
      endcase
    end

    // ***********************************
    // Register writes
    // ***********************************
    if (req.wr) begin
      case (req.addr)
        `FIDP_A_CONFIG: begin
          s_next.mode = req.wdata[`FIDP_CFG_MODE_LO +: 2];
          s_next.dir2_out = req.wdata[`FIDP_CFG_DIR2_BIT];
        end
        `FIDP_A_PORT_VAL: begin
          s_next.port_val = req.wdata[`FIDP_PORT_BITS-1:0];
        end
        `FIDP_A_RELAY: begin
          // Refused outside relay mode; the request is dropped
          if (relay_mode) begin
            s_next.relay_req = req.wdata[`FIDP_RELAY_BITS-1:0];
          end else begin
            s_next.relay_err = 1'b1;
          end
        end
        `FIDP_A_QUES_ENABLE: begin
          s_next.ques_en = req.wdata;
        end
        `FIDP_A_OPER_ENABLE: begin
          s_next.oper_en = req.wdata;
        end
        `FIDP_A_STD_ENABLE: begin
          s_next.std_en = req.wdata[7:0];
        end
        `FIDP_A_PROT: begin
          // Clear only takes once the inhibit line is released
          if (req.wdata[`FIDP_PROT_CLEAR_BIT] && !inhibit_asserted) begin
            s_next.ri_tripped = 1'b0;
          end
        end
        `FIDP_A_STATUS: begin
          if (req.wdata[`FIDP_STAT_ERR_CLR_BIT]) begin
            s_next.relay_err = 1'b0;
          end
        end
        `FIDP_A_SRQ_ENABLE: begin
          s_next.srq_en = req.wdata[`FIDP_SRQ_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // ***********************************
    // Event latching
    // ***********************************
    // Sets come after the clears so a same-cycle event is kept
    s_next.ques_ev = s_next.ques_ev | ques_cond_in;
    s_next.oper_ev = s_next.oper_ev | oper_cond_in;
    s_next.std_ev = s_next.std_ev | std_event_in;
    // Inhibit only trips in fault mode; there line three is its input
    if (fault_mode && inhibit_asserted) begin
      s_next.ri_tripped = 1'b1;
      s_next.ques_ev = s_next.ques_ev | ri_mask;
    end

    // ***********************************
    // Relay link
    // ***********************************
    // Start bit, 8 data bits LSB first, stop bit; readback shifted in alongside
    if (s_reg.div_cnt == `FIDP_RELAY_DIV) begin
      s_next.div_cnt = 16'h0000;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 16'h0001;
    end
    if (!relay_mode) begin
      // Leaving relay mode aborts a frame and releases line one
      s_next.tx_state = fidp_pkg::FIDP_TX_IDLE;
      s_next.tx_shift = 10'h3FF;
    end else if (s_reg.div_cnt == `FIDP_RELAY_DIV) begin
      case (s_reg.tx_state)
        fidp_pkg::FIDP_TX_IDLE: begin
          s_next.tx_state = fidp_pkg::FIDP_TX_SHIFT;
          s_next.tx_shift = {1'b1, s_reg.relay_req, 1'b0};
          s_next.bit_cnt = 4'h0;
        end
        fidp_pkg::FIDP_TX_SHIFT: begin
          s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt >= `FIDP_RELAY_FIRST_DATA && s_reg.bit_cnt <= `FIDP_RELAY_LAST_DATA) begin
            s_next.rx_shift = {s_reg.rtn_level, s_reg.rx_shift[7:1]};
          end
          if (s_reg.bit_cnt == `FIDP_RELAY_STOP_CNT) begin
            s_next.tx_state = fidp_pkg::FIDP_TX_IDLE;
            s_next.relay_rb = s_reg.rx_shift;
          end
        end
        default: begin
          s_next.tx_state = fidp_pkg::FIDP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.mode <= `FIDP_MODE_FAULT_INH;
      s_reg.inh_sync <= 3'h7;
      s_reg.inh_level <= 1'b1;
      s_reg.rtn_sync <= 3'h7;
      s_reg.rtn_level <= 1'b1;
      s_reg.tx_shift <= 10'h3FF;
    end else begin
      s_reg <= s_next;
    end
  end

  // ***********************************
  // Outputs and pins
  // ***********************************
  assign reg_rdata = s_reg.rdata;
  // Analog programming path cannot be shut off by inhibit
  assign output_enable = analog_prog_active | !s_reg.ri_tripped;
  assign prot_indicator = s_reg.ri_tripped;
  assign service_request = s_reg.srq_en & sum.ques_summary;

  // ***********************************
  // Pin drivers
  // ***********************************
  // Open-collector pins: drive low when enabled, otherwise released
  always_comb begin
    line1_out = 1'b0;
    line2_out = 1'b0;
    line3_out = 1'b0;
    line1_oe = 1'b0;
    line2_oe = 1'b0;
    line3_oe = 1'b0;
    case (s_reg.mode)
      `FIDP_MODE_FAULT_INH: begin
        line1_oe = fault_active;
      end
      `FIDP_MODE_DIGIO: begin
        line1_oe = !s_reg.port_val[0];
        line2_oe = !s_reg.port_val[1];
        line3_oe = s_reg.dir2_out & !s_reg.port_val[2];
      end
      `FIDP_MODE_RELAY: begin
        line1_oe = !s_reg.tx_shift[0];
      end
      default: begin
        // Reserved mode leaves every line released
      end
    endcase
  end

endmodule : fidp_port

/* File: verification/fidp_port_monitor.sv */
`timescale 1ns/100ps
module fidp_port_monitor (
  // Clock, reset and register writes
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // Protection side and pins
  input wire logic analog_prog_active,
  input wire logic output_enable,
  input wire logic prot_indicator,
  input wire logic service_request,
  input wire logic line1_oe,
  input wire logic line2_oe,
  input wire logic line3_in,
  input wire logic line3_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] mode_reg;
  wire clr_wr = reg_wr && reg_addr == 4'h9 && reg_wdata[0];
  // Mode is not a port, so shadow it from the writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= 2'h0;
    end else if (reg_wr && reg_addr == 4'h0) begin
      mode_reg <= reg_wdata[1:0];
    end
  end
  sequence s_inh_low;
    (mode_reg == 2'h0 && !line3_in) [*4];
  endsequence
  property p_reset_idle;
    $fell(rst) |-> output_enable && !line1_oe && !line2_oe && !line3_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Pins not idle after reset");
  property p_trip;
    s_inh_low |-> ##[0:4] prot_indicator;
  endproperty
  a_trip: assert property (p_trip)
    else $error("Held inhibit did not trip");
  property p_hold;
    prot_indicator && !clr_wr |=> prot_indicator;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Trip dropped without clear");
  property p_inh_off;
    prot_indicator && !analog_prog_active |-> !output_enable;
  endproperty
  a_inh_off: assert property (p_inh_off)
    else $error("Output on while tripped");
  property p_analog;
    analog_prog_active |-> output_enable;
  endproperty
  a_analog: assert property (p_analog)
    else $error("Analog path disabled");
  property p_srq;
    service_request && mode_reg == 2'h0 |-> ##[0:1] line1_oe;
  endproperty
  a_srq: assert property (p_srq)
    else $error("Service request without fault pin");
  property p_relay_l2;
    mode_reg == 2'h2 |-> !line2_oe;
  endproperty
  a_relay_l2: assert property (p_relay_l2)
    else $error("Line two driven in relay mode");
  property p_dio;
    reg_wr && reg_addr == 4'h1 && mode_reg == 2'h1 |=>
      line1_oe == !$past(reg_wdata[0]) && line2_oe == !$past(reg_wdata[1]);
  endproperty
  a_dio: assert property (p_dio)
    else $error("Port bits wrong on lines one and two");
endmodule : fidp_port_monitor

bind fidp_port fidp_port_monitor u_mon (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .analog_prog_active,
  .output_enable, .prot_indicator, .service_request, .line1_oe, .line2_oe, .line3_in, .line3_oe);

/* File: verification/fidp_partner.sv */
`timescale 1ns/100ps
module fidp_partner #(
  parameter int BIT_CLKS = 1000,
  parameter logic [7:0] READBACK = 8'h96
) (
  // Clock
  input wire logic ref_clk,
  // Port drives
  input wire logic line1_oe,
  input wire logic line2_oe,
  input wire logic line3_oe,
  // Bench controls
  input wire logic attached,
  input wire logic ext_low3,
  // Line levels
  output logic line1_in,
  output logic line2_in,
  output logic line3_in,
  // Byte decoded from the last full frame on line one
  output logic [7:0] relay_byte
);
  logic [7:0] rx_byte = 8'h00;
  int cnt = 0;
  logic busy = 1'b0;
  logic prev = 1'b1;
  logic bit_out;
  // Pull-ups: any released line reads high
  assign line1_in = !line1_oe;
  assign line2_in = !line2_oe;
  assign line3_in = !(line3_oe || ext_low3 || (busy && !bit_out));
  // Start bit slot is released; data follow LSB first
  assign bit_out = (cnt < BIT_CLKS) ? 1'b1 : READBACK[(cnt / BIT_CLKS) - 1];
  // Accessory syncs on the falling start edge of each frame
  always @(posedge ref_clk) begin
    prev <= line1_in;
    if (!busy && attached && prev && !line1_in) begin
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      busy <= cnt < 9 * BIT_CLKS - 1;
      if (cnt >= BIT_CLKS && cnt % BIT_CLKS == BIT_CLKS / 2) begin
        rx_byte <= {line1_in, rx_byte[7:1]};
      end
      if (cnt == 9 * BIT_CLKS - 1) begin
        relay_byte <= rx_byte;
      end
    end
  end
endmodule : fidp_partner

/* File: verification/fault_inhibit_digital_port_tb.sv */
`timescale 1ns/100ps
module fault_inhibit_digital_port_tb;
  logic ref_clk, rst, reg_wr, reg_rd, analog_prog_active, ext_low3, attached;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ques_cond_in, oper_cond_in, d;
  logic [7:0] std_event_in, relay_byte;
  logic output_enable, prot_indicator, service_request;
  logic line1_in, line1_oe, line2_in, line2_oe, line3_in, line3_oe;
  int bad_count, tests_run, cycles;
  wire logic [15:0] fl = {10'h000, service_request, output_enable, prot_indicator, line1_oe, line2_oe, line3_oe};

  fidp_port uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ques_cond_in,
    .oper_cond_in, .std_event_in, .analog_prog_active, .output_enable, .prot_indicator, .service_request,
    .line1_in, .line1_out(), .line1_oe, .line2_in, .line2_out(), .line2_oe, .line3_in, .line3_out(), .line3_oe);
  fidp_partner u_far (.ref_clk, .line1_oe, .line2_oe, .line3_oe, .attached, .ext_low3, .line1_in, .line2_in,
    .line3_in, .relay_byte);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic pulse(input int g);
    @(posedge ref_clk);
    {std_event_in, oper_cond_in, ques_cond_in} <= 40'h00_0000_0001 << (16 * g);
    @(posedge ref_clk);
    {std_event_in, oper_cond_in, ques_cond_in} <= 40'h00_0000_0000;
    cyc(3);
  endtask : pulse

  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Relay frames are long; the ceiling leaves room for three of them
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, analog_prog_active, ext_low3, attached} = 5'h00;
    {reg_addr, reg_wdata, ques_cond_in, oper_cond_in, std_event_in} = 60'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    chk("reset_pins", fl, 16'h0010);
    rd(4'h0);
    chk("config", d, 16'h0000);
    rd(4'hF);
    chk("unmapped", d, 16'h0000);
    wr(4'hB, 16'h0001);
    for (int g = 0; g < 3; g++) begin
      pulse(g);
      chk("masked", fl, 16'h0010);
      rd(4'h3 + 4'(2 * g));
      wr(4'h4 + 4'(2 * g), 16'h0001);
      pulse(g);
      chk("fault", fl, (g == 0) ? 16'h0034 : 16'h0014);
      rd(4'h3 + 4'(2 * g));
      chk("event", d, 16'h0001);
      cyc(2);
      chk("cleared", fl, 16'h0010);
      wr(4'h4 + 4'(2 * g), 16'h0000);
    end
    @(posedge ref_clk) ext_low3 <= 1'b1;
    cyc(10);
    chk("trip", fl, 16'h0008);
    rd(4'h3);
    chk("ri_event", d, 16'h0200);
    wr(4'h9, 16'h0001);
    cyc(2);
    chk("clear_held", fl, 16'h0008);
    @(posedge ref_clk) analog_prog_active <= 1'b1;
    cyc(1);
    chk("analog", fl, 16'h0018);
    @(posedge ref_clk) analog_prog_active <= 1'b0;
    ext_low3 <= 1'b0;
    cyc(10);
    chk("released", fl, 16'h0008);
    wr(4'h9, 16'h0001);
    cyc(2);
    chk("restored", fl, 16'h0010);
    wr(4'h2, 16'h00FF);
    rd(4'hA);
    chk("relay_err", d & 16'h0030, 16'h0020);
    rd(4'h2);
    chk("relay_refused", d, 16'h0000);
    wr(4'h0, 16'h0001);
    for (int v = 0; v < 8; v++) begin
      @(posedge ref_clk) ext_low3 <= ~v[2];
      wr(4'h1, 16'(v));
      cyc(6);
      chk("dio_pins", fl, 16'h0010 | 16'({~v[0], ~v[1], 1'b0}));
      rd(4'h1);
      chk("dio_sense", 16'(d[2]), 16'(v[2]));
    end
    @(posedge ref_clk) ext_low3 <= 1'b0;
    wr(4'h0, 16'h0005);
    wr(4'h1, 16'h0003);
    cyc(2);
    chk("dio_out3", fl, 16'h0011);
    wr(4'h0, 16'h0002);
    attached <= 1'b1;
    wr(4'h2, 16'h00A5);
    cyc(25000);
    rd(4'h2);
    chk("readback", d, 16'h96A5);
    chk("relay_tx", 16'(relay_byte), 16'h00A5);
    chk("line2_idle", 16'(line2_oe), 16'h0000);
    results();
  end
endmodule : fault_inhibit_digital_port_tb
